// [uart_rx_error_filter_timeout_bench.sv]
/*
  self-checking bench of the receive checker with a flag model.
  assumes urft_defines.svh on the include path and urft_tx_model as line driver.
*/
`timescale 1ns/1ps
`include "urft_defines.svh"
module uart_rx_error_filter_timeout_bench import urft_pkg::*; ;
    logic        sys_clk;
    logic        resetn;
    logic        rx_pin;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        irq;
    int          mismatches;
    int          n_compared;
    logic [31:0] seed;
    logic [31:0] got;
    logic        m_rdy, m_fr, m_pe, m_to;
    logic [7:0]  m_data;
    logic [2:0]  m_kind;
    logic [3:0]  m_ist, m_mask;

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    urft_tx_model tx (.sys_clk(sys_clk), .rx_line(rx_pin));
    urft_rx_checker uut (.sys_clk(sys_clk), .resetn(resetn), .rx_pin(rx_pin), .addr(addr),
                         .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
                         .rd_data(rd_data), .irq(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic par_of(input logic [2:0] k, input logic [7:0] d);
        case (k)
            3'h0: par_of = ^d;
            3'h1: par_of = ~^d;
            3'h2: par_of = 1'b0;
            default: par_of = 1'b1;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic chk_stat();
        rd(`URFT_STAT_OFS, got);
        chk(got, {28'h0, m_to, m_pe, m_fr, m_rdy});
    endtask

    task automatic chk_irq();
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, {31'h0, |(m_ist & m_mask)});
    endtask

    task automatic rx_char(input logic bad_par, input logic stop, input logic glitch);
        logic [7:0] d;
        logic       pon;
        seed = lfsr(seed);
        d = seed[7:0];
        pon = m_kind < 3'h4;
        tx.send(d, pon, par_of(m_kind, d) ^ bad_par, stop, glitch);
        repeat (32) @(posedge sys_clk);
        m_rdy = 1'b1;
        m_fr = m_fr | ~stop;
        m_pe = m_pe | (bad_par & pon);
        m_data = d;
        m_ist = m_ist | {1'b0, bad_par & pon, ~stop, 1'b1};
    endtask

    task automatic rd_char();
        rd(`URFT_DATA_OFS, got);
        chk(got, {24'h0, m_data});
        m_rdy = 1'b0;
    endtask

    task automatic clr_err();
        wr(`URFT_CTRL_OFS, 32'h1);
        m_fr = 1'b0;
        m_pe = 1'b0;
    endtask

    task automatic idle_chk(input int clks, input logic to_now);
        repeat (clks) @(posedge sys_clk);
        if (to_now) begin
            m_to = 1'b1;
            m_ist[3] = 1'b1;
        end
        chk_stat();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hc108;
        resetn = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        {m_rdy, m_fr, m_pe, m_to, m_ist, m_mask} = '0;
        m_data = 8'h00;
        m_kind = 3'h4;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`URFT_MODE_OFS, got);
        chk(got, 32'h8);
        rd(`URFT_DELAY_OFS, got);
        chk(got, 32'h0);
        rd(`URFT_BAUD_OFS, got);
        chk(got, 32'ha);
        rd(8'h20, got);
        chk(got, 32'h0);
        chk_stat();
        wr(`URFT_BAUD_OFS, 32'h1);
        wr(`URFT_IMASK_OFS, 32'h1);
        m_mask = 4'h1;
        rx_char(1'b0, 1'b1, 1'b0);
        chk_stat();
        chk_irq();
        rx_char(1'b0, 1'b0, 1'b0);
        chk_stat();
        rd(`URFT_ISTAT_OFS, got);
        chk(got, {28'h0, m_ist});
        m_ist = 4'h0;
        chk_irq();
        wr(`URFT_IMASK_OFS, 32'h2);
        m_mask = 4'h2;
        rd_char();
        rx_char(1'b0, 1'b1, 1'b0);
        chk_stat();
        chk_irq();
        clr_err();
        chk_stat();
        for (int k = 0; k < 4; k++) begin
            m_kind = k[2:0];
            wr(`URFT_MODE_OFS, {28'h0, m_kind, 1'b0});
            rx_char(1'b0, 1'b1, 1'b0);
            chk_stat();
            rx_char(1'b1, 1'b1, 1'b0);
            rd_char();
            chk_stat();
            clr_err();
            chk_stat();
        end
        m_kind = 3'h0;
        wr(`URFT_MODE_OFS, 32'h1);
        rd(`URFT_MODE_OFS, got);
        chk(got, 32'h1);
        rx_char(1'b0, 1'b1, 1'b1);
        rd_char();
        chk_stat();
        m_kind = 3'h4;
        wr(`URFT_MODE_OFS, 32'h8);
        wr(`URFT_DELAY_OFS, 32'h14);
        wr(`URFT_CTRL_OFS, 32'h4);
        repeat (100) @(posedge sys_clk);
        rx_char(1'b0, 1'b1, 1'b0);
        chk_stat();
        idle_chk(240, 1'b0);
        idle_chk(128, 1'b1);
        wr(`URFT_CTRL_OFS, 32'h2);
        m_to = 1'b0;
        idle_chk(480, 1'b0);
        rx_char(1'b0, 1'b1, 1'b0);
        idle_chk(400, 1'b1);
        wr(`URFT_CTRL_OFS, 32'h4);
        m_to = 1'b0;
        chk_stat();
        idle_chk(250, 1'b0);
        idle_chk(150, 1'b1);
        wr(`URFT_DELAY_OFS, 32'h0);
        m_to = 1'b0;
        wr(`URFT_CTRL_OFS, 32'h4);
        idle_chk(480, 1'b0);
        rd(`URFT_ISTAT_OFS, got);
        chk(got, {28'h0, m_ist});
        conclude();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
endmodule // uart_rx_error_filter_timeout_bench

// [urft_defines.svh]
/*
  register offsets, field positions, reset values and counts of the receive checker.
  assumes a byte-addressed register port with 32-bit words.
*/
`ifndef URFT_DEFINES_SVH
`define URFT_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define URFT_CTRL_OFS     8'h00
`define URFT_MODE_OFS     8'h04
`define URFT_STAT_OFS     8'h08
`define URFT_DELAY_OFS    8'h0c
`define URFT_DATA_OFS     8'h10
`define URFT_BAUD_OFS     8'h14
`define URFT_IMASK_OFS    8'h18
`define URFT_ISTAT_OFS    8'h1c

// ----------------------------------------
// field positions
// ----------------------------------------
`define URFT_CLR_ERR_BIT  0
`define URFT_WAIT_BIT     1
`define URFT_RELOAD_BIT   2
`define URFT_FILT_BIT     0
`define URFT_PAR_LSB      1
`define URFT_PAR_MSB      3

// ----------------------------------------
// parity kinds
// ----------------------------------------
`define URFT_PAR_EVEN     3'h0
`define URFT_PAR_ODD      3'h1
`define URFT_PAR_SPACE    3'h2
`define URFT_PAR_MARK     3'h3

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define URFT_BAUD_RST     16'h000a
`define URFT_PAR_RST      3'h4
`define URFT_OVS_LAST     4'hf
`define URFT_OVS_MID      4'h7
`define URFT_BITS_LAST    3'h7

`endif

// [urft_maj_filter.sv]
/*
  three-sample majority filter clocked by the 16x sample enable.
  assumes line_in is already synchronised to sys_clk.
*/
`timescale 1ns/1ps
module urft_maj_filter import urft_pkg::*; (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic line_in,
    input  wire logic sample_en,
    output logic      line_out
);
    urft_filt_s s_q;
    urft_filt_s s_d;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    always_comb begin
        s_d = s_q;
        if (sample_en) begin
            s_d.smp  = {s_q.smp[0], line_in};
            s_d.line = maj3(line_in, s_q.smp[0], s_q.smp[1]);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{smp: 2'h3, line: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign line_out = s_q.line;

    majority_vote_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sample_en |=> line_out == maj3($past(line_in), $past(s_q.smp[0]), $past(s_q.smp[1])))
        else $error("filtered line is not the majority of three samples");
endmodule // urft_maj_filter

// [urft_pkg.sv]
/*
  types of the receive checker: state encodings and state records.
  assumes urft_defines.svh is on the include path.
*/
package urft_pkg;

    typedef enum logic [2:0] {
        URFT_IDLE   = 3'h0,
        URFT_START  = 3'h1,
        URFT_DATA   = 3'h3,
        URFT_PARITY = 3'h2,
        URFT_STOP   = 3'h6
    } urft_rx_state_e;

    typedef struct packed {
        urft_rx_state_e state;
        logic [15:0]    div_cnt;
        logic [3:0]     smp_cnt;
        logic [2:0]     bit_cnt;
        logic [7:0]     shift;
        logic           perr_pend;
        logic [7:0]     rx_data;
        logic           rdy;
        logic           frame_err;
        logic           par_err;
        logic           timeout;
        logic           filter_en;
        logic [2:0]     par_kind;
        logic [7:0]     idle_delay;
        logic [15:0]    baud_div;
        logic [3:0]     int_mask;
        logic [3:0]     int_stat;
        logic [7:0]     to_cnt;
        logic           to_run;
        logic [3:0]     bit_sub;
        logic [31:0]    rd_data;
        logic           irq;
    } urft_state_s;

    typedef struct packed {
        logic [1:0] smp;
        logic       line;
    } urft_filt_s;

endpackage

// [urft_rx_checker.sv]
/*
  receive-side checker of an asynchronous serial port: framing and parity
  errors, optional majority filter, idle-line timeout, register port, interrupt.
  assumes one clock, register strobes one cycle long, 8 data bits, 1 stop bit.
*/
// Chosen here: the placing of the registers and strobed register access.
// Contract
// - after start and data bits, a stop bit at 0 sets frame error with ready
// - frame error holds until a control write with clear-errors at 1
// - line filter is off after reset, on only when mode filter bit is written 1
// - filtered line is the majority of last three 16x samples
// - idle delay zero disables timeout; timeout flag stays 0
// - nonzero delay loads 8-bit counter, decrements per bit, reloads per character
// - counter reaching zero sets the timeout flag, which may interrupt
// - idle-wait start halts the counter until the next character arrives
// - idle reload restarts the counter at once from the programmed delay
// - parity mismatch sets parity error with ready; only clear-errors clears it
`timescale 1ns/1ps
`include "urft_defines.svh"
module urft_rx_checker import urft_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        rx_pin,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rd_data,
    output logic             irq
);
    urft_state_s s_q;
    urft_state_s s_d;
    logic        rx_sync;
    logic        rx_filt;
    logic        line;
    logic        tick16;
    logic        bit_tick;
    logic        clr_err;
    logic        wait_cmd;
    logic        reload_cmd;
    logic        char_done;
    logic        ev_ferr;
    logic        ev_perr;
    logic        ev_to;
    logic        exp_par;

    // ----------------------------------------
    // pin input and filter
    // ----------------------------------------
    urft_sync u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .pin_in   (rx_pin),
        .pin_sync (rx_sync)
    );

    urft_maj_filter u_filt (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .line_in   (rx_sync),
        .sample_en (tick16),
        .line_out  (rx_filt)
    );

    assign line     = s_q.filter_en ? rx_filt : rx_sync;
    assign tick16   = (s_q.div_cnt == 16'h0000);
    assign bit_tick = tick16 && (s_q.bit_sub == `URFT_OVS_LAST);

    always_comb begin
        case (s_q.par_kind)
            `URFT_PAR_EVEN:  exp_par = ^s_q.shift;
            `URFT_PAR_ODD:   exp_par = ~^s_q.shift;
            `URFT_PAR_SPACE: exp_par = 1'b0;
            default:         exp_par = 1'b1;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d        = s_q;
        char_done  = 1'b0;
        ev_ferr    = 1'b0;
        ev_perr    = 1'b0;
        ev_to      = 1'b0;
        clr_err    = wr_en && addr == `URFT_CTRL_OFS && wr_data[`URFT_CLR_ERR_BIT];
        wait_cmd   = wr_en && addr == `URFT_CTRL_OFS && wr_data[`URFT_WAIT_BIT];
        reload_cmd = wr_en && addr == `URFT_CTRL_OFS && wr_data[`URFT_RELOAD_BIT];

        // baud divider for the 16x sample enable
        if (tick16) begin
            s_d.div_cnt = (s_q.baud_div == 16'h0000) ? 16'h0000 : s_q.baud_div - 16'h0001;
            s_d.bit_sub = s_q.bit_sub + 4'h1;
        end else begin
            s_d.div_cnt = s_q.div_cnt - 16'h0001;
        end

        // register writes
        if (wr_en) begin
            case (addr)
                `URFT_MODE_OFS: begin
                    s_d.filter_en = wr_data[`URFT_FILT_BIT];
                    s_d.par_kind  = wr_data[`URFT_PAR_MSB:`URFT_PAR_LSB];
                end
                `URFT_DELAY_OFS: s_d.idle_delay = wr_data[7:0];
                `URFT_BAUD_OFS:  s_d.baud_div   = wr_data[15:0];
                `URFT_IMASK_OFS: s_d.int_mask   = wr_data[3:0];
                default: ;
            endcase
        end

        // register reads, answered one cycle later
        s_d.rd_data = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                `URFT_MODE_OFS:  s_d.rd_data = {28'h0, s_q.par_kind, s_q.filter_en};
                `URFT_STAT_OFS:  s_d.rd_data = {28'h0, s_q.timeout, s_q.par_err,
                                                s_q.frame_err, s_q.rdy};
                `URFT_DELAY_OFS: s_d.rd_data = {24'h0, s_q.idle_delay};
                `URFT_DATA_OFS:  s_d.rd_data = {24'h0, s_q.rx_data};
                `URFT_BAUD_OFS:  s_d.rd_data = {16'h0, s_q.baud_div};
                `URFT_IMASK_OFS: s_d.rd_data = {28'h0, s_q.int_mask};
                `URFT_ISTAT_OFS: s_d.rd_data = {28'h0, s_q.int_stat};
                default:         s_d.rd_data = 32'h0000_0000;
            endcase
        end
        if (rd_en && addr == `URFT_DATA_OFS) begin
            s_d.rdy = 1'b0;
        end
        if (clr_err) begin
            s_d.frame_err = 1'b0;
            s_d.par_err   = 1'b0;
        end

        // character receiver
        if (tick16) begin
            case (s_q.state)
                URFT_IDLE: begin
                    if (!line) begin
                        s_d.state   = URFT_START;
                        s_d.smp_cnt = 4'h0;
                    end
                end
                URFT_START: begin
                    s_d.smp_cnt = s_q.smp_cnt + 4'h1;
                    if (s_q.smp_cnt == `URFT_OVS_MID) begin
                        s_d.state   = line ? URFT_IDLE : URFT_DATA;
                        s_d.smp_cnt = 4'h0;
                        s_d.bit_cnt = 3'h0;
                    end
                end
                URFT_DATA: begin
                    s_d.smp_cnt = s_q.smp_cnt + 4'h1;
                    if (s_q.smp_cnt == `URFT_OVS_LAST) begin
                        s_d.shift   = {line, s_q.shift[7:1]};
                        s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                        if (s_q.bit_cnt == `URFT_BITS_LAST) begin
                            s_d.perr_pend = 1'b0;
                            s_d.state     = (s_q.par_kind[2]) ? URFT_STOP : URFT_PARITY;
                        end
                    end
                end
                URFT_PARITY: begin
                    s_d.smp_cnt = s_q.smp_cnt + 4'h1;
                    if (s_q.smp_cnt == `URFT_OVS_LAST) begin
                        s_d.perr_pend = (line != exp_par);
                        s_d.state     = URFT_STOP;
                    end
                end
                URFT_STOP: begin
                    s_d.smp_cnt = s_q.smp_cnt + 4'h1;
                    if (s_q.smp_cnt == `URFT_OVS_LAST) begin
                        char_done   = 1'b1;
                        ev_ferr     = !line;
                        ev_perr     = s_q.perr_pend;
                        s_d.rx_data = s_q.shift;
                        s_d.state   = URFT_IDLE;
                    end
                end
                default: s_d.state = URFT_IDLE;
            endcase
        end

        // flags: a set in the same cycle as a clear wins
        if (char_done) begin
            s_d.rdy = 1'b1;
        end
        if (ev_ferr) begin
            s_d.frame_err = 1'b1;
        end
        if (ev_perr) begin
            s_d.par_err = 1'b1;
        end

        // idle timeout
        if (wait_cmd) begin
            s_d.timeout = 1'b0;
            s_d.to_run  = 1'b0;
        end
        if (reload_cmd) begin
            s_d.timeout = 1'b0;
            s_d.to_cnt  = s_q.idle_delay;
            s_d.to_run  = 1'b1;
        end else if (s_q.to_run && bit_tick) begin
            s_d.to_cnt = s_q.to_cnt - 8'h01;
            if (s_q.to_cnt == 8'h01) begin
                ev_to       = 1'b1;
                s_d.timeout = 1'b1;
                s_d.to_run  = 1'b0;
            end
        end
        if (char_done) begin
            s_d.to_cnt = s_q.idle_delay;
            s_d.to_run = 1'b1;
        end
        if (s_d.idle_delay == 8'h00) begin
            ev_to       = 1'b0;
            s_d.timeout = 1'b0;
            s_d.to_run  = 1'b0;
        end

        // interrupt status, cleared by its read
        if (rd_en && addr == `URFT_ISTAT_OFS) begin
            s_d.int_stat = 4'h0;
        end
        s_d.int_stat = s_d.int_stat | {ev_to, ev_perr, ev_ferr, char_done};
        s_d.irq      = |(s_d.int_stat & s_d.int_mask);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.state    <= URFT_IDLE;
            s_q.baud_div <= `URFT_BAUD_RST;
            s_q.par_kind <= `URFT_PAR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign irq     = s_q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence stop_sample_s;
        tick16 && s_q.state == URFT_STOP && s_q.smp_cnt == `URFT_OVS_LAST;
    endsequence

    sequence clr_write_s;
        wr_en && addr == `URFT_CTRL_OFS && wr_data[`URFT_CLR_ERR_BIT];
    endsequence

    frame_error_set_a: assert property (
        stop_sample_s ##0 !line |=> s_q.frame_err && s_q.rdy)
        else $error("frame error not raised with ready");

    frame_error_hold_a: assert property (
        s_q.frame_err && !clr_err |=> s_q.frame_err)
        else $error("frame error dropped without clear command");

    filter_enable_a: assert property (
        $rose(s_q.filter_en) |-> $past(wr_en && addr == `URFT_MODE_OFS))
        else $error("filter enabled without a mode write");

    timeout_off_a: assert property (
        s_q.idle_delay == 8'h00 |-> !s_q.timeout && !s_q.to_run)
        else $error("timeout active with zero delay");

    char_reload_a: assert property (
        stop_sample_s ##0 s_d.idle_delay != 8'h00 |=> s_q.to_cnt == $past(s_q.idle_delay))
        else $error("idle counter not reloaded on character");

    timeout_expire_a: assert property (
        s_q.to_run && bit_tick && s_q.to_cnt == 8'h01 && !reload_cmd && s_d.idle_delay != 8'h00
        |=> s_q.timeout && s_q.int_stat[3])
        else $error("timeout flag not set at count zero");

    wait_halt_a: assert property (
        wait_cmd && !reload_cmd && !char_done
        |=> !s_q.to_run ##1 ($stable(s_q.to_cnt) || $past(reload_cmd || char_done)))
        else $error("idle counter runs after wait command");

    reload_cmd_a: assert property (
        reload_cmd && !char_done && s_d.idle_delay != 8'h00
        |=> s_q.to_run && s_q.to_cnt == $past(s_q.idle_delay) && !s_q.timeout)
        else $error("reload command did not restart idle counter");

    parity_error_a: assert property (
        stop_sample_s ##0 s_q.perr_pend |=> s_q.par_err && s_q.rdy)
        else $error("parity error not raised with ready");

    cmd_clears_to_a: assert property (
        (wait_cmd || reload_cmd) && !ev_to |=> !s_q.timeout)
        else $error("idle command left timeout pending");

    clear_errors_a: assert property (
        clr_write_s ##0 (!ev_ferr && !ev_perr) |=> !s_q.frame_err && !s_q.par_err)
        else $error("clear command left an error flag set");

    parity_hold_a: assert property (
        s_q.par_err && !clr_err |=> s_q.par_err)
        else $error("parity error dropped without clear command");

    frame_clean_a: assert property (
        stop_sample_s ##0 (line && !s_q.frame_err) |=> !s_q.frame_err)
        else $error("frame error raised on a good stop bit");

    ready_with_char_a: assert property (
        stop_sample_s |=> s_q.rdy && s_q.int_stat[0])
        else $error("ready not raised at stop sample");

    start_glitch_a: assert property (
        tick16 && s_q.state == URFT_START && s_q.smp_cnt == `URFT_OVS_MID && line
        |=> s_q.state == URFT_IDLE)
        else $error("start glitch not dropped");

    filter_disable_a: assert property (
        $fell(s_q.filter_en) |-> $past(wr_en && addr == `URFT_MODE_OFS))
        else $error("filter disabled without a mode write");

    sequence halted_s;
        !s_q.to_run && !reload_cmd && !char_done;
    endsequence

    halted_count_a: assert property (
        halted_s |=> $stable(s_q.to_cnt))
        else $error("idle counter moved while halted");

    count_down_a: assert property (
        s_q.to_run && bit_tick && s_q.to_cnt != 8'h01 && !reload_cmd && !char_done
        |=> s_q.to_cnt == $past(s_q.to_cnt) - 8'h01)
        else $error("idle counter did not count one bit period");

    timeout_source_a: assert property (
        !s_q.timeout && !(s_q.to_run && bit_tick && s_q.to_cnt == 8'h01) |=> !s_q.timeout)
        else $error("timeout flag set without counter expiry");

    expire_stop_a: assert property (
        ev_to && !char_done |=> !s_q.to_run)
        else $error("idle counter still runs after expiry");
endmodule // urft_rx_checker

// [urft_sync.sv]
/*
  two-flop synchroniser for the receive pin.
  assumes an idle-high serial line.
*/
`timescale 1ns/1ps
module urft_sync import urft_pkg::*; (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic [1:0] s_q;
    logic [1:0] s_d;

    always_comb begin
        s_d = {s_q[0], pin_in};
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= 2'h3;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q[1];
endmodule // urft_sync

// [urft_tx_model.sv]
/*
  remote serial transmitter that drives the receive line of the checker.
  assumes the bench calls send from its main process; line idles high.
*/
`timescale 1ns/1ps
module urft_tx_model import urft_pkg::*; #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic sys_clk,
    output logic      rx_line
);
    // ----------------------------------------
    // character sender
    // ----------------------------------------
    initial rx_line = 1'b1;

    task automatic send(input logic [7:0] d, input logic par_on, input logic par_bit,
                        input logic stop_bit, input logic glitch);
        logic [10:0] frame;
        int          nbits;
        nbits = par_on ? 11 : 10;
        frame = par_on ? {stop_bit, par_bit, d, 1'b0} : {1'b1, stop_bit, d, 1'b0};
        for (int i = 0; i < nbits; i++) begin
            for (int c = 0; c < BIT_CLKS; c++) begin
                @(posedge sys_clk);
                rx_line <= frame[i] ^ (glitch && c == BIT_CLKS / 2);
            end
        end
        @(posedge sys_clk);
        rx_line <= 1'b1;
    endtask
endmodule // urft_tx_model
